// [rtl/rwi_defs.svh]
// constants for the reset and wake-up register initialisation block
`ifndef RWI_DEFS_SVH
`define RWI_DEFS_SVH
`define RWI_VEC_HIGH 21'h000008
`define RWI_VEC_LOW 21'h000018
`define RWI_PC_RESET 21'h000000
`define RWI_SP_RESET 5'h00
`define RWI_SP_MAX 5'h1F
`define RWI_PORT_A_PINS_POR 8'h00
`define RWI_PORT_A_PINS_KEEP_MASK 8'hD0
`define RWI_DIR_POR 8'hFF
`define RWI_LATCH_POR 8'h00
`define RWI_PERIOD_POR 8'hFF
`define RWI_CAPTURE_POR 16'h0000
`define RWI_TCON_POR 8'h00
`define RWI_TCON_MASK 8'h7F
`define RWI_UPPER_PA_BITS 8'hC0
`endif

// [rtl/rwi_pkg.sv]
// types for the reset and wake-up register initialisation block
package rwi_pkg;
	// reset and wake-up condition classes
	typedef enum logic [1:0]
	{
		RWI_NONE = 2'h0,
		RWI_COLD = 2'h1,
		RWI_WARM = 2'h3,
		RWI_WAKE = 2'h2
	} rwi_cond_e;
	// stacked return address split into bytes
	typedef struct packed
	{
		logic [4:0] upper;
		logic [7:0] high;
		logic [7:0] low;
	} rwi_tos_s;
	// write request into the held registers
	typedef struct packed
	{
		logic we;
		logic [2:0] sel;
		logic [7:0] data;
	} rwi_wr_s;
endpackage

// [rtl/rwi_sync.sv]
// two-flop synchroniser for pin inputs
module rwi_sync
#(
	parameter int W = 1
)
(
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// asynchronous level in, synchronised level out
	input wire logic [W-1:0] D,
	output logic [W-1:0] Q
);
	logic [W-1:0] meta_r; // first stage, read only by second
	// two stages
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			meta_r <= '0;
			Q <= '0;
		end
		else
		begin
			meta_r <= D;
			Q <= meta_r;
		end
	end
endmodule

// [rtl/rwi_top.sv]
// reset classes, wake-up vectoring and held register initialisation
// Notes on behaviour
// - enabled interrupt wake-up loads matching vector
// - enabled wake-up pushes program counter to stack-top
// - enabled wake-up advances stack pointer by one, holding at 1F
// - every wake-up sets a source flag
// - port A bits 6,7 follow oscillator mode
// - unimplemented bits always read zero
// - three condition classes, distinct initial states
`include "rwi_defs.svh"
module rwi_top
(
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// reset and wake causes, one-cycle pulses from core logic
	input wire logic COLD_RST,
	input wire logic WARM_RST,
	input wire logic WAKE_WATCHDOG,
	input wire logic WAKE_INT,
	input wire logic WAKE_INT_HIGH,
	// global enables and oscillator mode
	input wire logic HIGH_PRIO_GLOBAL_INT_ENABLE,
	input wire logic LOW_PRIO_GLOBAL_INT_ENABLE,
	input wire logic OSC_FREES_RA67,
	// core program counter and pin levels
	input wire logic [20:0] PC_IN,
	input wire logic [7:0] PORT_A_PINS_IN,
	// register writes from core
	input wire rwi_pkg::rwi_wr_s WR,
	// program counter load
	output logic PC_LOAD,
	output logic [20:0] PC_OUT,
	// stack state
	output rwi_pkg::rwi_tos_s STACK_TOP,
	output logic [4:0] STACK_POINTER_REG,
	// wake flags and condition
	output logic WAKE_FLAG_WATCHDOG,
	output logic WAKE_FLAG_INT,
	output rwi_pkg::rwi_cond_e LAST_COND,
	// held register values
	output logic [7:0] PORT_A_READ,
	output logic [7:0] PORT_A_LATCH,
	output logic [7:0] PORT_A_DIRECTION,
	output logic [7:0] TIMER4_PERIOD,
	output logic [7:0] TIMER4_CON,
	output logic [15:0] CAPTURE4
);
	// decoded conditions, cold wins over warm, warm over wake
	wire logic is_cold = COLD_RST;
	wire logic is_warm = WARM_RST && !COLD_RST;
	wire logic any_wake = (WAKE_WATCHDOG || WAKE_INT)
		&& !COLD_RST && !WARM_RST;
	wire logic int_en = HIGH_PRIO_GLOBAL_INT_ENABLE
		|| LOW_PRIO_GLOBAL_INT_ENABLE;
	wire logic vec_wake = any_wake && WAKE_INT && int_en;
	// high vector chosen when the high-priority source caused wake and the high-priority enable is set
	wire logic use_high = WAKE_INT_HIGH && HIGH_PRIO_GLOBAL_INT_ENABLE;
	wire logic [20:0] vec_addr = use_high ? `RWI_VEC_HIGH : `RWI_VEC_LOW;
	wire logic [7:0] pa_mask;
	logic [7:0] pa_sync;
	rwi_pkg::rwi_cond_e cond_nxt;
	logic [4:0] sp_r;
	rwi_pkg::rwi_tos_s tos_r;
	logic [7:0] lat_r;
	logic [7:0] dir_r;
	logic [7:0] per_r;
	logic [7:0] tcon_r;
	logic [15:0] cap_r;
	logic [7:0] pins_r;
	logic wflag_wdog_r;
	logic wflag_int_r;

	// mask of implemented port A bits under current oscillator mode
	assign pa_mask = OSC_FREES_RA67 ? 8'hFF : ~`RWI_UPPER_PA_BITS;

	// pins pass two flops before use
	rwi_sync #(.W(8)) u_sync
	(
		.CLK(CLK),
		.RESET_N(RESET_N),
		.D(PORT_A_PINS_IN),
		.Q(pa_sync)
	);

	// condition class encoding
	assign cond_nxt = is_cold ? rwi_pkg::RWI_COLD
		: is_warm ? rwi_pkg::RWI_WARM
		: any_wake ? rwi_pkg::RWI_WAKE : LAST_COND;

	// vectoring on enabled interrupt wake
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			PC_LOAD <= 1'b0;
			PC_OUT <= `RWI_PC_RESET;
		end
		else
		begin
			PC_LOAD <= vec_wake || is_cold || is_warm;
			if (vec_wake)
				PC_OUT <= vec_addr;
			else if (is_cold || is_warm)
				PC_OUT <= `RWI_PC_RESET;
		end
	end

	// stack push on enabled interrupt wake
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			sp_r <= `RWI_SP_RESET;
			tos_r <= '0;
		end
		else if (is_cold || is_warm)
		begin
			sp_r <= `RWI_SP_RESET;
			tos_r <= '0;
		end
		else if (vec_wake)
		begin
			tos_r <= PC_IN;
			sp_r <= (sp_r == `RWI_SP_MAX) ? sp_r : sp_r + 5'h01;
		end
	end

	// wake source flags, a new wake sets them
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			wflag_wdog_r <= 1'b0;
			wflag_int_r <= 1'b0;
		end
		else if (is_cold || is_warm)
		begin
			wflag_wdog_r <= 1'b0;
			wflag_int_r <= 1'b0;
		end
		else if (any_wake)
		begin
			wflag_wdog_r <= wflag_wdog_r || WAKE_WATCHDOG;
			wflag_int_r <= wflag_int_r || WAKE_INT;
		end
	end

	// class register
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			LAST_COND <= rwi_pkg::RWI_NONE;
		else
			LAST_COND <= cond_nxt;
	end

	// port A latch and direction: cold sets pattern, warm sets direction only, wake keeps
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			lat_r <= `RWI_LATCH_POR;
			dir_r <= `RWI_DIR_POR;
		end
		else if (is_cold)
		begin
			lat_r <= `RWI_LATCH_POR;
			dir_r <= `RWI_DIR_POR;
		end
		else if (is_warm)
			dir_r <= `RWI_DIR_POR;
		else if (WR.we && !any_wake)
		begin
			if (WR.sel == 3'h0)
				lat_r <= WR.data;
			if (WR.sel == 3'h1)
				dir_r <= WR.data;
		end
	end

	// port A read image: cold clears all bits, warm clears low nibble and bit 5
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			pins_r <= `RWI_PORT_A_PINS_POR;
		else if (is_cold)
			pins_r <= `RWI_PORT_A_PINS_POR;
		else if (is_warm)
			pins_r <= pins_r & `RWI_PORT_A_PINS_KEEP_MASK;
		else if (!any_wake)
			pins_r <= pa_sync;
	end

	// timer 4 period, control and capture
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			per_r <= `RWI_PERIOD_POR;
			tcon_r <= `RWI_TCON_POR;
			cap_r <= `RWI_CAPTURE_POR;
		end
		else if (is_cold)
		begin
			per_r <= `RWI_PERIOD_POR;
			tcon_r <= `RWI_TCON_POR;
			cap_r <= `RWI_CAPTURE_POR;
		end
		else if (is_warm)
			tcon_r <= `RWI_TCON_POR;
		else if (WR.we && !any_wake)
		begin
			if (WR.sel == 3'h2)
				per_r <= WR.data;
			if (WR.sel == 3'h3)
				tcon_r <= WR.data & `RWI_TCON_MASK;
			if (WR.sel == 3'h4)
				cap_r[7:0] <= WR.data;
			if (WR.sel == 3'h5)
				cap_r[15:8] <= WR.data;
		end
	end

	// outputs, unimplemented bits forced to zero
	assign PORT_A_READ = pins_r & pa_mask;
	assign PORT_A_LATCH = lat_r & pa_mask;
	assign PORT_A_DIRECTION = dir_r & pa_mask;
	assign TIMER4_PERIOD = per_r;
	assign TIMER4_CON = tcon_r & `RWI_TCON_MASK;
	assign CAPTURE4 = cap_r;
	assign STACK_TOP = tos_r;
	assign STACK_POINTER_REG = sp_r;
	assign WAKE_FLAG_WATCHDOG = wflag_wdog_r;
	assign WAKE_FLAG_INT = wflag_int_r;

	// checks
	property p_vec;
		@(posedge CLK) disable iff (!RESET_N)
		vec_wake |=> PC_LOAD && (PC_OUT == $past(vec_addr));
	endproperty
	vector_load_a: assert property (p_vec) else $error("vector not loaded");
	stack_push_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		vec_wake |=> STACK_TOP == $past(PC_IN)) else $error("no push");
	sp_advance_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		vec_wake && sp_r != 5'h1F |=> sp_r == $past(sp_r) + 5'h01)
		else $error("sp not advanced");
	wake_flag_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		any_wake |=> WAKE_FLAG_WATCHDOG || WAKE_FLAG_INT)
		else $error("no wake flag");
	port_a_pins_upper_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		!OSC_FREES_RA67 |-> (PORT_A_READ[7:6] == 2'h0)
		&& (PORT_A_LATCH[7:6] == 2'h0) && (PORT_A_DIRECTION[7:6] == 2'h0))
		else $error("upper port bits live");
	tcon_unimpl_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		TIMER4_CON[7] == 1'b0) else $error("unimpl bit set");
	warm_class_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		is_warm |=> LAST_COND == rwi_pkg::RWI_WARM
		&& TIMER4_CON == 8'h00) else $error("warm init wrong");
	wake_keep_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		any_wake |=> $stable(TIMER4_PERIOD) && $stable(CAPTURE4))
		else $error("wake changed regs");
	cold_period_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		is_cold |=> TIMER4_PERIOD == 8'hFF) else $error("period");
	cover_vec_c: cover property (@(posedge CLK) vec_wake);
	cover_wdog_c: cover property (@(posedge CLK) any_wake && WAKE_WATCHDOG);
	cover_warm_c: cover property (@(posedge CLK) is_warm);
endmodule

// [dv/rwi_top_bench.sv]
// self-checking bench for the reset and wake-up initialisation block
module rwi_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// stimulus: clock, reset, causes, enables, core values
	logic clk, rst_n, cold, warm, wwdt, wint, whigh, hen, len, osc;
	logic [20:0] pc_in;
	logic [7:0] pins;
	rwi_pkg::rwi_wr_s wr;
	// observed outputs
	logic pc_load, fl_wdog, fl_int;
	logic [20:0] pc_out;
	rwi_pkg::rwi_tos_s tos;
	logic [4:0] sp;
	rwi_pkg::rwi_cond_e cond;
	logic [7:0] pa_rd, pa_lat, pa_dir, per, tcon;
	logic [15:0] cap;
	// verdict counters
	int fails, cmp_count;

	// device under test
	rwi_top dut
	(
		.CLK(clk), .RESET_N(rst_n), .COLD_RST(cold), .WARM_RST(warm),
		.WAKE_WATCHDOG(wwdt), .WAKE_INT(wint), .WAKE_INT_HIGH(whigh),
		.HIGH_PRIO_GLOBAL_INT_ENABLE(hen), .LOW_PRIO_GLOBAL_INT_ENABLE(len),
		.OSC_FREES_RA67(osc), .PC_IN(pc_in), .PORT_A_PINS_IN(pins),
		.WR(wr), .PC_LOAD(pc_load), .PC_OUT(pc_out), .STACK_TOP(tos),
		.STACK_POINTER_REG(sp), .WAKE_FLAG_WATCHDOG(fl_wdog),
		.WAKE_FLAG_INT(fl_int), .LAST_COND(cond), .PORT_A_READ(pa_rd),
		.PORT_A_LATCH(pa_lat), .PORT_A_DIRECTION(pa_dir),
		.TIMER4_PERIOD(per), .TIMER4_CON(tcon), .CAPTURE4(cap)
	);

	// free-running core clock, 50 ns period
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// compare seen against expected, report at once
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one-cycle cause pulse {cold,warm,wdt,int}, then one idle cycle
	task cause(input logic [3:0] c);
		{cold, warm, wwdt, wint} = c;
		@(negedge clk);
		{cold, warm, wwdt, wint} = 4'h0;
		@(negedge clk);
	endtask

	// one-cycle register write, then one idle cycle
	task wrt(input logic [2:0] s, input logic [7:0] d);
		wr = '{we: 1'b1, sel: s, data: d};
		@(negedge clk);
		wr = '{we: 1'b0, sel: 3'h0, data: 8'h00};
		@(negedge clk);
	endtask

	// state straight after the asynchronous reset
	task reset_state;
		chk(pa_dir, 8'h3F);
		chk(per, 8'hFF);
		chk(tcon, 8'h00);
		chk(cap, 16'h0000);
		chk(sp, 5'h00);
		chk(pc_load, 1'b0);
		chk(fl_int, 1'b0);
	endtask

	// enabled interrupt wake: vector, stack push, pointer step
	task wake_vec(input logic hi, input logic [20:0] pc, input logic [20:0] v);
		logic [4:0] sp0;
		sp0 = sp;
		whigh = hi;
		hen = hi;
		len = !hi;
		pc_in = pc;
		wint = 1'b1;
		@(negedge clk);
		wint = 1'b0;
		chk(pc_load, 1'b1);
		chk(pc_out, v);
		chk(tos, pc);
		chk(sp, sp0 + 5'h01);
		chk(fl_int, 1'b1);
		chk(cond, rwi_pkg::RWI_WAKE);
		@(negedge clk);
		chk(pc_load, 1'b0);
	endtask

	// wakes that must not vector, flags cleared by warm reset
	task wake_plain;
		logic [4:0] sp0;
		sp0 = sp;
		hen = 1'b0;
		len = 1'b0;
		cause(4'h1);
		chk(sp, sp0);
		chk(pc_out, 21'h000018);
		cause(4'h4);
		chk(fl_int, 1'b0);
		chk(cond, rwi_pkg::RWI_WARM);
		cause(4'h2);
		chk(fl_wdog, 1'b1);
		chk(fl_int, 1'b0);
	endtask

	// held registers across wake, warm and cold
	task regs_keep;
		osc = 1'b1;
		wrt(3'h0, 8'hA5);
		wrt(3'h1, 8'h5A);
		wrt(3'h2, 8'h3C);
		wrt(3'h3, 8'hFF);
		wrt(3'h4, 8'h34);
		wrt(3'h5, 8'h12);
		chk(pa_lat, 8'hA5);
		chk(tcon, 8'h7F);
		cause(4'h1);
		chk({pa_dir, per, cap}, 32'h5A3C1234);
		chk(tcon, 8'h7F);
		cause(4'h4);
		chk({pa_dir, per, tcon}, 32'h00FF3C00);
		chk({pa_lat, cap}, 32'h00A51234);
		osc = 1'b0;
		@(negedge clk);
		chk({pa_dir, pa_lat}, 32'h00003F25);
		cause(4'h8);
		chk({per, cap}, 32'h00FF0000);
		chk(cond, rwi_pkg::RWI_COLD);
	endtask

	// pin image upper bits follow the oscillator mode
	task pins_mask;
		pins = 8'hC3;
		osc = 1'b1;
		repeat (4) @(negedge clk);
		chk(pa_rd, 8'hC3);
		osc = 1'b0;
		repeat (2) @(negedge clk);
		chk(pa_rd, 8'h03);
	endtask

	// refused writes, cause priority, low vector, pointer saturation
	task refused;
		// a write in a wake cycle is dropped
		wr = '{we: 1'b1, sel: 3'h2, data: 8'h11};
		wwdt = 1'b1;
		@(negedge clk);
		wr = '{we: 1'b0, sel: 3'h0, data: 8'h00};
		wwdt = 1'b0;
		@(negedge clk);
		chk(per, 8'hFF);
		chk(fl_wdog, 1'b1);
		// cold and warm together count as cold
		cause(4'hC);
		chk(cond, rwi_pkg::RWI_COLD);
		chk(fl_wdog, 1'b0);
		// high source with only the low enable takes the low vector
		whigh = 1'b1;
		hen = 1'b0;
		len = 1'b1;
		cause(4'h1);
		chk(pc_out, 21'h000018);
		chk(sp, 5'h01);
		// warm in a wake cycle wins, wake flag stays clear
		cause(4'h5);
		chk(fl_int, 1'b0);
		chk(sp, 5'h00);
		// pointer stops at its top
		repeat (32) cause(4'h1);
		chk(sp, 5'h1F);
	endtask

	// print counts and verdict, end the run
	task test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// main sequence
	initial
	begin
		{rst_n, cold, warm, wwdt, wint, whigh, hen, len, osc} = 9'h000;
		pc_in = 21'h000000;
		pins = 8'h00;
		wr = '{we: 1'b0, sel: 3'h0, data: 8'h00};
		fails = 0;
		cmp_count = 0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		reset_state;
		wake_vec(1'b1, 21'h1A5C3, 21'h000008);
		wake_vec(1'b0, 21'h0F00E, 21'h000018);
		wake_plain;
		regs_keep;
		pins_mask;
		refused;
		test_done;
	end

	// hang guard: a run past its bound is a mismatch
	initial
	begin
		repeat (5000) @(posedge clk);
		fails++;
		test_done;
	end
endmodule
